// ### adcsq_consts.vh
`ifndef ADCSQ_CONSTS_VH
`define ADCSQ_CONSTS_VH
// Register word indices, taken from byte address bits 7:2
`define ADCSQ_OFS_CMD     6'h00
`define ADCSQ_OFS_SETUP   6'h01
`define ADCSQ_OFS_CHSET   6'h04
`define ADCSQ_OFS_CHCLR   6'h05
`define ADCSQ_OFS_CHSTATE 6'h06
`define ADCSQ_OFS_FLAGS   6'h07
`define ADCSQ_OFS_LATEST  6'h08
`define ADCSQ_OFS_IRQSET  6'h09
`define ADCSQ_OFS_IRQCLR  6'h0a
`define ADCSQ_OFS_IRQSTAT 6'h0b
`define ADCSQ_OFS_RES0    6'h0c
`define ADCSQ_OFS_RES7    6'h13
// Command fields
`define ADCSQ_CMD_SOFT_RESET_BIT   0
`define ADCSQ_CMD_START   1
// Setup fields
`define ADCSQ_SU_HW_TRIGGER_ENABLE    0
`define ADCSQ_SU_TRIGGER_SELECT   3:1
`define ADCSQ_SU_LOW_RESOLUTION   4
`define ADCSQ_SU_SLEEP    5
`define ADCSQ_SU_PRESC    13:8
`define ADCSQ_SU_START    20:16
`define ADCSQ_SU_SHT      27:24
`define ADCSQ_SU_MASK     32'h0f1f3f3f
`define ADCSQ_SU_RESET    32'h00000000
// Flag fields
`define ADCSQ_FL_DONE     7:0
`define ADCSQ_FL_OVR      15:8
`define ADCSQ_FL_DATA_READY     16
`define ADCSQ_FL_GOVR     17
`define ADCSQ_FL_RX_COUNT_END    18
`define ADCSQ_FL_RXBUF    19
`define ADCSQ_IRQ_MASK    32'h000fffff
// Trigger select codes
`define ADCSQ_TRG_TMR0    3'h0
`define ADCSQ_TRG_TMR1    3'h1
`define ADCSQ_TRG_TMR2    3'h2
`define ADCSQ_TRG_EXT     3'h6
// Start-up interval multiplier in converter clocks
`define ADCSQ_STARTUP_MUL 4'h8
`endif

// ### adcsq_top.v
`timescale 1ns/1ps
`include "adcsq_consts.vh"

// Overview of operation
// - Soft reset bit restores reset state, edge histories aside
// - Start bit launches sequence over enabled channels
// - Trigger disabled: only software starts count
// - Trigger enabled: selected source starts too
// - Codes 0-2 timers, 6 external pin
// - Converter clock is master over 2(p+1)
// - Start-up waits 8 times (field+1) clocks
// - Sample-hold lasts field converter clocks
// - Enable register ones enable channels
// - Disable register ones disable channels
// - Channel state shows enabled channels
// - Done flags need enabled and completed
// - Overrun flags per channel since read
// - Data ready flags unread latest result
// - General overrun flag since last read
// - Receive count end since counter write
// - Buffers full when both counters zero
// - Latest result held until next conversion
// - Mask set register ones set masks
// - Mask clear register ones clear masks
// - Mask state mirrors flag layout
// - Low resolution gives 8-bit results, bytes
// - Sleep powers cell per sequence; triggers still start it
// - Result reads clear done; latest read clears ready too
// - Overwrites set overruns; flag read clears
module adcsq_top #(
   parameter NUM_CH  = 8,
   parameter RES_W   = 10
) (
   input  wire              REF_CLK,
   input  wire              RST_N,
   input  wire              CE,
   input  wire              WB_CYC_I,
   input  wire              WB_STB_I,
   input  wire              WB_WE_I,
   input  wire [7:0]        WB_ADR_I,
   input  wire [3:0]        WB_SEL_I,
   input  wire [31:0]       WB_DAT_I,
   output wire [31:0]       WB_DAT_O,
   output wire              WB_ACK_O,
   input  wire [2:0]        TIMER_WAVE_OUTPUT,
   input  wire              EXTERNAL_TRIGGER_PIN,
   output wire              CONVERTER_CLOCK,
   output wire              ADC_POWER_ON,
   output wire [2:0]        ADC_CHANNEL_SEL,
   output wire              ADC_SAMPLE,
   output wire              ADC_CONVERT_START,
   input  wire              ADC_DONE,
   input  wire [RES_W-1:0]  ADC_RESULT,
   input  wire              DMA_RX_COUNT_ZERO,
   input  wire              DMA_RX_NEXT_ZERO,
   input  wire              DMA_COUNTER_WRITE,
   output wire              DMA_RX_REQ,
   output wire              DMA_BYTE_XFER,
   output wire              IRQ
);

   localparam S_IDLE   = 2'h0;
   localparam S_WAKE   = 2'h1;
   localparam S_SAMPLE = 2'h2;
   localparam S_CONV   = 2'h3;

   reg                ack_q;
   reg  [31:0]        dat_q;
   reg  [31:0]        setup_q;
   reg  [NUM_CH-1:0]  chen_q;
   reg  [NUM_CH-1:0]  done_q;
   reg  [NUM_CH-1:0]  ovr_q;
   reg                data_ready_q;
   reg                govr_q;
   reg                rx_count_end_q;
   reg                zero_prev_q;
   reg  [19:0]        imask_q;
   reg  [RES_W-1:0]   res_q [0:NUM_CH-1];
   reg  [RES_W-1:0]   latest_q;
   reg  [2:0]         latest_ch_q;
   reg  [1:0]         state_q;
   reg  [2:0]         ch_q;
   reg  [15:0]        cnt_q;
   reg  [5:0]         div_q;
   reg                cclk_q;
   reg                power_q;
   reg                conv_go_q;
   reg                dma_req_q;
   reg                trig_prev_q;

   wire        acc   = WB_CYC_I & WB_STB_I & ~ack_q;
   wire        wr    = acc & WB_WE_I;
   wire        rd    = acc & ~WB_WE_I;
   wire [5:0]  idx   = WB_ADR_I[7:2];
   wire [31:0] bmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                        {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
   wire [31:0] wd    = WB_DAT_I & bmask;
   wire [5:0]  res_off = idx - `ADCSQ_OFS_RES0;
   wire [2:0]  res_i = res_off[2:0];
   wire        res_hit = (idx >= `ADCSQ_OFS_RES0) &&
                         (idx <= `ADCSQ_OFS_RES7);

   wire sw_rst   = wr && idx == `ADCSQ_OFS_CMD &&
                   wd[`ADCSQ_CMD_SOFT_RESET_BIT];
   wire sw_start = wr && idx == `ADCSQ_OFS_CMD &&
                   wd[`ADCSQ_CMD_START];
   wire [2:0] tsel  = setup_q[`ADCSQ_SU_TRIGGER_SELECT];
   wire       low_resolution = setup_q[`ADCSQ_SU_LOW_RESOLUTION];
   wire       sleep  = setup_q[`ADCSQ_SU_SLEEP];
   wire [5:0] presc  = setup_q[`ADCSQ_SU_PRESC];
   wire [4:0] stup   = setup_q[`ADCSQ_SU_START];
   wire [3:0] sht    = setup_q[`ADCSQ_SU_SHT];

   // Selected hardware trigger; reserved codes stay low for good
   reg trig_lvl;
   always @* begin
      case (tsel)
         `ADCSQ_TRG_TMR0: trig_lvl = TIMER_WAVE_OUTPUT[0];
         `ADCSQ_TRG_TMR1: trig_lvl = TIMER_WAVE_OUTPUT[1];
         `ADCSQ_TRG_TMR2: trig_lvl = TIMER_WAVE_OUTPUT[2];
         `ADCSQ_TRG_EXT:  trig_lvl = EXTERNAL_TRIGGER_PIN;
         default:         trig_lvl = 1'b0;
      endcase
   end

   // Rising edge only counts while triggers are enabled
   wire hw_start = setup_q[`ADCSQ_SU_HW_TRIGGER_ENABLE] &
                   trig_lvl & ~trig_prev_q;
   wire start_req = sw_start | hw_start;

   // Tick marks each rising edge of the converter clock
   wire div_wrap = (div_q == presc);
   wire tick     = div_wrap & ~cclk_q;

   // Next enabled channel at or above a given index
   function [3:0] next_ch;
      input [NUM_CH-1:0] m;
      input [3:0]        from;
      integer i;
      begin
         next_ch = 4'h0;
         for (i = NUM_CH - 1; i >= 0; i = i - 1) begin
            if (m[i] && i >= from) begin
               next_ch = {1'b1, i[2:0]};
            end
         end
      end
   endfunction

   wire [3:0]  first_ch = next_ch(chen_q, 4'h0);
   wire [3:0]  after_ch = next_ch(chen_q, {1'b0, ch_q} + 4'h1);
   wire [8:0]  wake_len = {4'h0, stup} * {5'h0, `ADCSQ_STARTUP_MUL}
                          + {5'h0, `ADCSQ_STARTUP_MUL};
   wire        done_ok  = (state_q == S_CONV) && ADC_DONE &&
                          chen_q[ch_q] && !conv_go_q;
   // Low resolution keeps the top eight bits, upper two read zero
   wire [RES_W-1:0] res_val = low_resolution ?
        {2'h0, ADC_RESULT[RES_W-1:2]} : ADC_RESULT;

   // Flag set and clear terms; a set in the clearing cycle wins
   reg [NUM_CH-1:0] done_clr;
   reg [NUM_CH-1:0] done_set;
   reg [NUM_CH-1:0] ovr_set;
   always @* begin
      done_clr = {NUM_CH{1'b0}};
      done_set = {NUM_CH{1'b0}};
      ovr_set  = {NUM_CH{1'b0}};
      if (rd && res_hit) begin
         done_clr[res_i] = 1'b1;
      end
      if (rd && idx == `ADCSQ_OFS_LATEST) begin
         done_clr[latest_ch_q] = 1'b1;
      end
      if (done_ok) begin
         done_set[ch_q] = 1'b1;
         ovr_set[ch_q]  = done_q[ch_q];
      end
   end

   wire flags_rd = rd && idx == `ADCSQ_OFS_FLAGS;
   wire rxbuf    = DMA_RX_COUNT_ZERO & DMA_RX_NEXT_ZERO;
   wire [31:0] flags = {12'h000, rxbuf, rx_count_end_q, govr_q, data_ready_q,
                        ovr_q, done_q & chen_q};

   // Register read multiplexer
   reg [31:0] rdata;
   always @* begin
      rdata = 32'h00000000;
      case (idx)
         `ADCSQ_OFS_SETUP:   rdata = setup_q;
         `ADCSQ_OFS_CHSTATE: rdata = {24'h000000, chen_q};
         `ADCSQ_OFS_FLAGS:   rdata = flags;
         `ADCSQ_OFS_LATEST:  rdata = {22'h000000, latest_q};
         `ADCSQ_OFS_IRQSTAT: rdata = {12'h000, imask_q};
         default: begin
            if (res_hit) begin
               rdata = {22'h000000, res_q[res_i]};
            end
         end
      endcase
   end

   // Bus answer: ack one cycle after the request, unmapped reads zero
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else if (CE) begin
         ack_q <= acc;
         if (rd) begin
            dat_q <= rdata;
         end
      end
   end

   // Per-channel result storage
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g = g + 1) begin : g_res
         always @(posedge REF_CLK or negedge RST_N) begin
            if (!RST_N) begin
               res_q[g] <= {RES_W{1'b0}};
            end else if (CE) begin
               if (sw_rst) begin
                  res_q[g] <= {RES_W{1'b0}};
               end else if (done_set[g]) begin
                  res_q[g] <= res_val;
               end
            end
         end
      end
   endgenerate

   // Configuration, flags and sequencer; soft reset mirrors hard reset but keeps zero_prev_q and trig_prev_q
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         setup_q     <= `ADCSQ_SU_RESET;
         chen_q      <= {NUM_CH{1'b0}};
         done_q      <= {NUM_CH{1'b0}};
         ovr_q       <= {NUM_CH{1'b0}};
         data_ready_q      <= 1'b0;
         govr_q      <= 1'b0;
         rx_count_end_q     <= 1'b1;
         zero_prev_q <= 1'b1;
         imask_q     <= 20'h00000;
         latest_q    <= {RES_W{1'b0}};
         latest_ch_q <= 3'h0;
         state_q     <= S_IDLE;
         ch_q        <= 3'h0;
         cnt_q       <= 16'h0000;
         div_q       <= 6'h00;
         cclk_q      <= 1'b0;
         power_q     <= 1'b0;
         conv_go_q   <= 1'b0;
         dma_req_q   <= 1'b0;
         trig_prev_q <= 1'b0;
      end else if (CE) begin
         if (sw_rst) begin
            setup_q     <= `ADCSQ_SU_RESET;
            chen_q      <= {NUM_CH{1'b0}};
            done_q      <= {NUM_CH{1'b0}};
            ovr_q       <= {NUM_CH{1'b0}};
            data_ready_q      <= 1'b0;
            govr_q      <= 1'b0;
            rx_count_end_q     <= 1'b1;
            imask_q     <= 20'h00000;
            latest_q    <= {RES_W{1'b0}};
            latest_ch_q <= 3'h0;
            state_q     <= S_IDLE;
            ch_q        <= 3'h0;
            cnt_q       <= 16'h0000;
            div_q       <= 6'h00;
            cclk_q      <= 1'b0;
            power_q     <= 1'b0;
            conv_go_q   <= 1'b0;
            dma_req_q   <= 1'b0;
         end else begin
            // Register writes
            if (wr && idx == `ADCSQ_OFS_SETUP) begin
               setup_q <= (setup_q & ~bmask) |
                          (wd & `ADCSQ_SU_MASK);
            end
            // Disabling mid-sequence is left to software to avoid
            chen_q <= (chen_q
               | ((wr && idx == `ADCSQ_OFS_CHSET) ?
                  wd[NUM_CH-1:0] : {NUM_CH{1'b0}}))
               & ~((wr && idx == `ADCSQ_OFS_CHCLR) ?
                  wd[NUM_CH-1:0] : {NUM_CH{1'b0}});
            imask_q <= (imask_q
               | ((wr && idx == `ADCSQ_OFS_IRQSET) ?
                  wd[19:0] : 20'h00000))
               & ~((wr && idx == `ADCSQ_OFS_IRQCLR) ?
                  wd[19:0] : 20'h00000);

            // Status flags, set beats clear
            done_q <= (done_q & ~done_clr) | done_set;
            ovr_q  <= (ovr_q & {NUM_CH{~flags_rd}}) | ovr_set;
            govr_q <= (govr_q & ~flags_rd) |
                      (done_ok & data_ready_q);
            data_ready_q <= (data_ready_q & ~(rd && idx == `ADCSQ_OFS_LATEST)) |
                      done_ok;
            zero_prev_q <= DMA_RX_COUNT_ZERO;
            rx_count_end_q <= (rx_count_end_q & ~DMA_COUNTER_WRITE) |
                       (DMA_RX_COUNT_ZERO & ~zero_prev_q);
            dma_req_q <= done_ok;
            if (done_ok) begin
               latest_q    <= res_val;
               latest_ch_q <= ch_q;
            end

            // Converter clock divider
            if (div_wrap) begin
               div_q  <= 6'h00;
               cclk_q <= ~cclk_q;
            end else begin
               div_q <= div_q + 6'h01;
            end
            trig_prev_q <= trig_lvl;
            conv_go_q   <= 1'b0;

            // Sequencer; starts outside idle are dropped
            case (state_q)
               S_IDLE: begin
                  if (!sleep) begin
                     power_q <= power_q;
                  end
                  if (start_req && first_ch[3]) begin
                     ch_q  <= first_ch[2:0];
                     cnt_q <= 16'h0000;
                     if (power_q) begin
                        state_q <= S_SAMPLE;
                     end else begin
                        power_q <= 1'b1;
                        state_q <= S_WAKE;
                     end
                  end
               end
               S_WAKE: begin
                  if (tick) begin
                     if (cnt_q + 16'h0001 >= {7'h00, wake_len}) begin
                        cnt_q   <= 16'h0000;
                        state_q <= S_SAMPLE;
                     end else begin
                        cnt_q <= cnt_q + 16'h0001;
                     end
                  end
               end
               S_SAMPLE: begin
                  if (sht == 4'h0 ||
                      (tick && cnt_q + 16'h0001 >= {12'h000, sht})) begin
                     cnt_q     <= 16'h0000;
                     conv_go_q <= 1'b1;
                     state_q   <= S_CONV;
                  end else if (tick) begin
                     cnt_q <= cnt_q + 16'h0001;
                  end
               end
               S_CONV: begin
                  if (ADC_DONE && !conv_go_q) begin
                     if (after_ch[3]) begin
                        ch_q    <= after_ch[2:0];
                        state_q <= S_SAMPLE;
                     end else begin
                        state_q <= S_IDLE;
                        if (sleep) begin
                           power_q <= 1'b0;
                        end
                     end
                  end
               end
               default: state_q <= S_IDLE;
            endcase
         end
      end
   end

   assign WB_ACK_O          = ack_q;
   assign WB_DAT_O          = dat_q;
   assign CONVERTER_CLOCK   = cclk_q;
   assign ADC_POWER_ON      = power_q;
   assign ADC_CHANNEL_SEL   = ch_q;
   assign ADC_SAMPLE        = (state_q == S_SAMPLE);
   assign ADC_CONVERT_START = conv_go_q;
   assign DMA_RX_REQ        = dma_req_q;
   assign DMA_BYTE_XFER     = low_resolution;
   // Single request line for all unmasked flags
   assign IRQ = |(flags[19:0] & imask_q);

endmodule

// ### adcsq_cell_model.sv
`timescale 1ns/1ps
// Analog cell stand-in: one done pulse per conversion start, LAT later
module adcsq_cell_model #(
   parameter LAT = 3
) (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       conv_start,
   input  wire [2:0] chan_sel,
   output reg        done,
   output reg  [9:0] result
);
   reg [3:0] cnt_q;
   reg [9:0] last_q;
   // Result is inverted outside done so a stale capture never matches
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
         last_q <= 10'h000;
         done <= 1'b0;
         result <= 10'h3ff;
      end else begin
         done <= 1'b0;
         result <= ~last_q;
         if (conv_start) begin
            cnt_q <= LAT;
            last_q <= {chan_sel, 7'h2b};
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               done <= 1'b1;
               result <= last_q;
            end
         end
      end
   end
endmodule

// ### adcsq_top_sva.sv
`timescale 1ns/1ps
// Sees the top ports only; mirrors enables and masks from bus writes
module adcsq_chk (
   input wire        REF_CLK,
   input wire        RST_N,
   input wire        CE,
   input wire        WB_CYC_I,
   input wire        WB_STB_I,
   input wire        WB_WE_I,
   input wire [7:0]  WB_ADR_I,
   input wire [3:0]  WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   input wire        WB_ACK_O,
   input wire        ADC_POWER_ON,
   input wire [2:0]  ADC_CHANNEL_SEL,
   input wire        ADC_SAMPLE,
   input wire        ADC_CONVERT_START,
   input wire        ADC_DONE,
   input wire        DMA_RX_REQ,
   input wire        DMA_BYTE_XFER,
   input wire        IRQ
);
   wire        take = CE & WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire        wr0 = take & WB_WE_I & WB_SEL_I[0];
   wire [5:0]  wadr = WB_ADR_I[7:2];
   wire        srst = wr0 && wadr == 6'h00 && WB_DAT_I[0];
   reg  [7:0]  en_q;
   reg  [19:0] msk_q;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // Mirror assumes full-lane writes, which is all the bench issues
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         en_q <= 8'h00;
         msk_q <= 20'h00000;
      end else if (srst) begin
         en_q <= 8'h00;
         msk_q <= 20'h00000;
      end else if (wr0) begin
         if (wadr == 6'h04) en_q <= en_q | WB_DAT_I[7:0];
         if (wadr == 6'h05) en_q <= en_q & ~WB_DAT_I[7:0];
         if (wadr == 6'h09) msk_q <= msk_q | WB_DAT_I[19:0];
         if (wadr == 6'h0a) msk_q <= msk_q & ~WB_DAT_I[19:0];
      end
   end
   property p_ack;
      take |=> WB_ACK_O ##1 !WB_ACK_O;
   endproperty
   a_ack: assert property (p_ack)
      else $error("ack is not a one-cycle answer");
   property p_srst;
      srst && !WB_DAT_I[1] |=> !ADC_POWER_ON && !ADC_SAMPLE && !DMA_BYTE_XFER;
   endproperty
   a_srst: assert property (p_srst)
      else $error("soft reset left state behind");
   property p_cst;
      ADC_CONVERT_START |=> !ADC_CONVERT_START;
   endproperty
   a_cst: assert property (p_cst)
      else $error("conversion start longer than one cycle");
   property p_pwr;
      ADC_SAMPLE |-> ADC_POWER_ON;
   endproperty
   a_pwr: assert property (p_pwr)
      else $error("sampling while unpowered");
   property p_shold;
      $rose(ADC_CONVERT_START) |-> $past(ADC_SAMPLE);
   endproperty
   a_shold: assert property (p_shold)
      else $error("conversion without sample phase");
   property p_chan;
      ADC_CONVERT_START |-> en_q[ADC_CHANNEL_SEL];
   endproperty
   a_chan: assert property (p_chan)
      else $error("disabled channel converted");
   property p_req;
      DMA_RX_REQ |-> $past(ADC_DONE);
   endproperty
   a_req: assert property (p_req)
      else $error("result request without cell done");
   property p_byte;
      wr0 && wadr == 6'h01 |=> DMA_BYTE_XFER == $past(WB_DAT_I[4]);
   endproperty
   a_byte: assert property (p_byte)
      else $error("transfer size not following resolution");
   property p_irq;
      msk_q == 20'h00000 |-> !IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt with all sources masked");
endmodule
bind adcsq_top adcsq_chk adcsq_chk_inst (
   .REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
   .ADC_POWER_ON(ADC_POWER_ON), .ADC_CHANNEL_SEL(ADC_CHANNEL_SEL),
   .ADC_SAMPLE(ADC_SAMPLE), .ADC_CONVERT_START(ADC_CONVERT_START),
   .ADC_DONE(ADC_DONE), .DMA_RX_REQ(DMA_RX_REQ),
   .DMA_BYTE_XFER(DMA_BYTE_XFER), .IRQ(IRQ));

// ### adcsq_top_tb.sv
`timescale 1ns/1ps
module adcsq_top_tb;
   reg         ref_clk = 1'b0;
   reg         rst_n = 1'b0;
   reg         ce = 1'b1;
   reg         cyc = 1'b0;
   reg         stb = 1'b0;
   reg         we = 1'b0;
   reg  [7:0]  adr = 8'h00;
   reg  [31:0] dat_w = 32'h0;
   reg  [2:0]  tmr = 3'h0;
   reg         ext = 1'b0;
   reg         cz = 1'b1;
   reg         nz = 1'b1;
   reg         cw = 1'b0;
   wire [31:0] dat_r;
   wire        ack, cclk, pwr, smp, cst, done, req, bx, irq;
   wire [2:0]  chs;
   wire [9:0]  res;
   integer     fails = 0;
   integer     cmp_count = 0;
   integer     req_cnt = 0;
   integer     base, n, i;
   realtime    t1;
   adcsq_top adcsq_top_inst (
      .REF_CLK(ref_clk), .RST_N(rst_n), .CE(ce), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
      .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
      .TIMER_WAVE_OUTPUT(tmr), .EXTERNAL_TRIGGER_PIN(ext),
      .CONVERTER_CLOCK(cclk), .ADC_POWER_ON(pwr), .ADC_CHANNEL_SEL(chs),
      .ADC_SAMPLE(smp), .ADC_CONVERT_START(cst), .ADC_DONE(done),
      .ADC_RESULT(res), .DMA_RX_COUNT_ZERO(cz), .DMA_RX_NEXT_ZERO(nz),
      .DMA_COUNTER_WRITE(cw), .DMA_RX_REQ(req), .DMA_BYTE_XFER(bx),
      .IRQ(irq));
   adcsq_cell_model adcsq_cell_model_inst (
      .clk(ref_clk), .rst_n(rst_n), .conv_start(cst), .chan_sel(chs),
      .done(done), .result(res));
   always #5 ref_clk = ~ref_clk;
   // Results are counted here so no one-cycle request is missed
   always @(posedge ref_clk) if (req === 1'b1) req_cnt <= req_cnt + 1;
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("BAD %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // One classic cycle; waits for ack, then one idle cycle
   task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
      integer k;
      begin
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         dat_w <= d;
         k = 0;
         @(posedge ref_clk);
         while (ack !== 1'b1 && k < 50) begin
            @(posedge ref_clk);
            k = k + 1;
         end
         if (k >= 50) fails = fails + 1;
         q = dat_r;
         cyc <= 1'b0;
         stb <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      reg [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task rc(input [7:0] a, input [31:0] exp, input string nm);
      reg [31:0] q;
      begin
         wb(1'b0, a, 32'h0, q);
         chk(nm, q, exp);
      end
   endtask
   task wait_req(input integer target);
      integer k;
      begin
         k = 0;
         while (req_cnt < target && k < 2000) begin
            @(posedge ref_clk);
            k = k + 1;
         end
         if (k >= 2000) fails = fails + 1;
      end
   endtask
   task chk_rst;
      begin
         rc(8'h04, 32'h0, "setup");
         rc(8'h18, 32'h0, "chstate");
         rc(8'h1c, 32'h000c0000, "flags");
         rc(8'h20, 32'h0, "latest");
         rc(8'h2c, 32'h0, "mask");
         rc(8'h50, 32'h0, "unmapped");
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", cmp_count, fails);
         if (fails == 0 && cmp_count > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // Span is well beyond the few thousand cycles the tests need
   initial begin
      #300000;
      fails = fails + 1;
      summarize;
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      chk_rst;
      cz <= 1'b0;
      nz <= 1'b0;
      cw <= 1'b1;
      @(posedge ref_clk);
      cw <= 1'b0;
      rc(8'h1c, 32'h0, "flags_cw");
      cz <= 1'b1;
      @(posedge ref_clk);
      rc(8'h1c, 32'h00040000, "flags_end");
      nz <= 1'b1;
      @(posedge ref_clk);
      rc(8'h1c, 32'h000c0000, "flags_full");
      wr(8'h04, 32'hffffffff);
      rc(8'h04, 32'h0f1f3f3f, "setup_rw");
      // Prescaler 2, start-up 0, sample-hold 2, software start only
      wr(8'h04, 32'h02000200);
      @(posedge cclk);
      t1 = $realtime;
      @(posedge cclk);
      chk("cclk", ($realtime - t1) / 10.0, 6);
      @(posedge ref_clk);
      // Clock enable low must freeze the divider for several periods
      ce <= 1'b0;
      @(posedge ref_clk);
      n = cclk;
      repeat (7) begin
         @(posedge ref_clk);
         chk("ce_freeze", cclk, n);
      end
      ce <= 1'b1;
      wr(8'h10, 32'h05);
      wr(8'h10, 32'h02);
      wr(8'h14, 32'h04);
      wr(8'h18, 32'hff);
      rc(8'h18, 32'h03, "chstate");
      base = req_cnt;
      wr(8'h00, 32'h2);
      n = 0;
      while (smp !== 1'b1 && n < 200) begin
         @(posedge ref_clk);
         n = n + 1;
      end
      chk("startup", n >= 41 && n <= 49, 1);
      n = 0;
      while (smp === 1'b1 && n < 200) begin
         @(posedge ref_clk);
         n = n + 1;
      end
      chk("sample", n >= 6 && n <= 13, 1);
      wait_req(base + 2);
      rc(8'h1c, 32'h000f0003, "flags_eoc");
      rc(8'h20, 32'h0ab, "latest");
      // Second pass overruns channel 0 only; latest read freed ch 1
      wr(8'h00, 32'h2);
      wait_req(base + 4);
      chk("irq_off", irq, 0);
      rc(8'h1c, 32'h000f0103, "flags_ovr");
      rc(8'h1c, 32'h000d0003, "flags_clr");
      wr(8'h24, 32'h00010001);
      wr(8'h28, 32'h00000001);
      rc(8'h2c, 32'h00010000, "mask");
      chk("irq_on", irq, 1);
      rc(8'h30, 32'h02b, "res0");
      rc(8'h1c, 32'h000d0002, "flags_r0");
      rc(8'h20, 32'h0ab, "latest2");
      rc(8'h1c, 32'h000c0000, "flags_lr");
      chk("irq_drop", irq, 0);
      // Hardware sources must be ignored while triggers are off
      base = req_cnt;
      {ext, tmr} <= 4'hf;
      repeat (4) @(posedge ref_clk);
      {ext, tmr} <= 4'h0;
      repeat (200) @(posedge ref_clk);
      chk("trg_off", req_cnt - base, 0);
      // Codes 0,1,2,6 then reserved 3,4; reserved sees every source
      for (i = 0; i < 6; i = i + 1) begin
         n = i < 3 ? i : (i == 3 ? 6 : i - 1);
         wr(8'h04, 32'h02000211 | (n << 1));
         base = req_cnt;
         {ext, tmr} <= i < 3 ? (4'h1 << i) : (i == 3 ? 4'h8 : 4'hf);
         repeat (4) @(posedge ref_clk);
         {ext, tmr} <= 4'h0;
         repeat (200) @(posedge ref_clk);
         chk("trg", req_cnt - base, i < 4 ? 2 : 0);
      end
      rc(8'h20, 32'h02a, "low_resolution");
      chk("bytes", bx, 1);
      // Sleep: second start inside the sequence must be dropped
      wr(8'h04, 32'h02000220);
      base = req_cnt;
      wr(8'h00, 32'h2);
      wr(8'h00, 32'h2);
      wait_req(base + 2);
      repeat (100) @(posedge ref_clk);
      chk("sleep_n", req_cnt - base, 2);
      chk("sleep_pwr", pwr, 0);
      wr(8'h00, 32'h1);
      chk_rst;
      summarize;
   end
endmodule
